//--- logic/cbc_config.sv
// Purpose: command-behaviour and burst-wrap configuration behind a serial link
// Assumes: SPI mode 0, SCK much slower than MCLK, zero read latency
// Notes:   non-volatile copies are modelled as flops loaded with their reset values by RST only
`timescale 1ns/100ps
`default_nettype none
`include "cbc_defs.svh"

// How it works
// - 65h reads, 71h writes these registers
// - any reset reloads volatile from non-volatile
// - non-volatile bits flip once, then stay
// - bit 5 enables blank check before erase
// - failed previous erase: erase without checking
// - good previous erase: scan, erase or skip
// - blank check covers all erase kinds
// - bit 4 picks 256 or 512 wrap
// - 256 mode wraps after location 255
// - bit 3 picks hybrid or uniform sectors
// - bit 2: 30h clears status or resumes
// - bit 1: D8h/DCh erase 64k or 256k
// - bit 0 enables F0h reset, else ignored
// - 66h then 99h always resets
// - burst wrap ignored by register reads
// - any reset reloads volatile burst wrap
// - C0h also writes volatile burst wrap
// - wrap enable only for quad reads
// - wrap length code 8/16/32/64 bytes
module cbc_config #(
    parameter int ADDR_BITS = 24,
    parameter int PBUF_BYTES = 512
) (
    input  wire  logic              MCLK,
    input  wire  logic              RST,
    input  wire  logic              SCK,
    input  wire  logic              CS_N,
    input  wire  logic              SI,
    input  wire  logic              HW_RESET_N,
    output logic                    SO,
    output logic                    SO_OE_N,
    output cbc_pkg::cbc_cfg3_t      CFG3_ACTIVE,
    output cbc_pkg::cbc_cfg4_t      WRAP_ACTIVE,
    output logic                    SOFT_RESET_PULSE,
    output logic                    CLEAR_STATUS_PULSE,
    output logic                    RESUME_PULSE,
    input  wire  logic              ERASE_REQ,
    input  wire  logic              SECTOR_ERASE_OK,
    input  wire  logic              BLANK_DONE,
    input  wire  logic              BLANK_ZERO_FOUND,
    output logic                    BLANK_SCAN_START,
    output logic                    ERASE_START,
    output logic                    ERASE_SKIP,
    input  wire  logic              PBUF_LOAD_START,
    input  wire  logic [8:0]        PBUF_START_ADDR,
    input  wire  logic              PBUF_LOAD_STROBE,
    output logic [8:0]              PBUF_ADDR
);
    import cbc_pkg::*;

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    if (ADDR_BITS != 24) begin : g_bad_addr
        $error("cbc_config: only 24 address bits supported");
    end
    if (PBUF_BYTES != 512) begin : g_bad_pbuf
        $error("cbc_config: page buffer must be 512 bytes");
    end

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [2:0]             sck_sync_reg;
    logic [1:0]             cs_sync_reg;
    logic [1:0]             si_sync_reg;
    logic [1:0]             hwr_sync_reg;
    logic                   sck_rise;
    logic                   sck_fall;
    logic                   cs_high;
    logic [7:0]             byte_next;
    cbc_spi_state_t         spi_state_reg;
    logic [7:0]             shift_in_reg;
    logic [7:0]             op_reg;
    logic [23:0]            addr_reg;
    logic [23:0]            addr_next;
    logic [4:0]             bit_cnt_reg;
    logic [7:0]             rd_shift_reg;
    logic                   rst_armed_reg;
    logic                   wr_pulse_reg;
    logic                   burst_pulse_reg;
    logic [23:0]            wr_addr_reg;
    logic [7:0]             wr_data_reg;
    logic [7:0]             cfg3_nv_reg;
    logic [7:0]             cfg3_used_reg;
    logic [7:0]             cfg4_nv_reg;
    logic [7:0]             cfg4_used_reg;
    logic [7:0]             cfg3_flip;
    logic [7:0]             cfg4_flip;
    logic                   reload;
    cbc_erase_state_t       erase_state_reg;

    // ------------------------------------------------------------------------
    // link synchronisers and edge detection
    // ------------------------------------------------------------------------
    // two flops per pin before any logic, third stage for edges
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sck_sync_reg <= 3'h0;
            cs_sync_reg  <= 2'h3;
            si_sync_reg  <= 2'h0;
            hwr_sync_reg <= 2'h3;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], SCK};
            cs_sync_reg  <= {cs_sync_reg[0], CS_N};
            si_sync_reg  <= {si_sync_reg[0], SI};
            hwr_sync_reg <= {hwr_sync_reg[0], HW_RESET_N};
        end
    end

    assign cs_high   = cs_sync_reg[1];
    assign sck_rise  = ~cs_high & sck_sync_reg[1] & ~sck_sync_reg[2];
    assign sck_fall  = ~cs_high & ~sck_sync_reg[1] & sck_sync_reg[2];
    assign byte_next = {shift_in_reg[6:0], si_sync_reg[1]};
    assign addr_next = {addr_reg[22:0], si_sync_reg[1]};
    assign reload    = SOFT_RESET_PULSE | ~hwr_sync_reg[1];

    // register read mux; reserved bits are zero in every stored copy
    function automatic logic [7:0] read_mux(input logic [23:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `CBC_ADDR_CFG3_NV: v = cfg3_nv_reg;
            `CBC_ADDR_CFG3_V:  v = CFG3_ACTIVE;
            `CBC_ADDR_CFG4_NV: v = cfg4_nv_reg;
            `CBC_ADDR_CFG4_V:  v = WRAP_ACTIVE;
            default:           v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    // ------------------------------------------------------------------------
    // command decoder
    // ------------------------------------------------------------------------
    // shifts opcode, address and data on rising SCK, sends on falling SCK
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            spi_state_reg      <= CBC_S_OPCODE;
            shift_in_reg       <= 8'h00;
            op_reg             <= 8'h00;
            addr_reg           <= 24'h000000;
            bit_cnt_reg        <= 5'h00;
            rd_shift_reg       <= 8'h00;
            rst_armed_reg      <= 1'b0;
            wr_pulse_reg       <= 1'b0;
            burst_pulse_reg    <= 1'b0;
            wr_addr_reg        <= 24'h000000;
            wr_data_reg        <= 8'h00;
            SO                 <= 1'b0;
            SO_OE_N            <= 1'b1;
            SOFT_RESET_PULSE   <= 1'b0;
            CLEAR_STATUS_PULSE <= 1'b0;
            RESUME_PULSE       <= 1'b0;
        end else begin
            wr_pulse_reg       <= 1'b0;
            burst_pulse_reg    <= 1'b0;
            SOFT_RESET_PULSE   <= 1'b0;
            CLEAR_STATUS_PULSE <= 1'b0;
            RESUME_PULSE       <= 1'b0;
            if (cs_high) begin
                spi_state_reg <= CBC_S_OPCODE;
                bit_cnt_reg   <= 5'h00;
                SO_OE_N       <= 1'b1;
            end else if (sck_rise) begin
                shift_in_reg <= byte_next;
                bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                case (spi_state_reg)
                    CBC_S_OPCODE: begin
                        if (bit_cnt_reg == 5'h07) begin
                            bit_cnt_reg   <= 5'h00;
                            op_reg        <= byte_next;
                            rst_armed_reg <= (byte_next == `CBC_OP_RST_ARM);
                            spi_state_reg <= CBC_S_IGNORE;
                            case (byte_next)
                                `CBC_OP_REG_READ, `CBC_OP_REG_WRITE: begin
                                    spi_state_reg <= CBC_S_ADDR;
                                end
                                `CBC_OP_SET_BURST: begin
                                    spi_state_reg <= CBC_S_WRITE;
                                end
                                `CBC_OP_RST_GO: begin
                                    SOFT_RESET_PULSE <= rst_armed_reg;
                                end
                                `CBC_OP_LEGACY_RST: begin
                                    SOFT_RESET_PULSE <= CFG3_ACTIVE.legacy_reset_enable;
                                end
                                `CBC_OP_CLR_RESUME: begin
                                    RESUME_PULSE       <= CFG3_ACTIVE.clear_or_resume_select;
                                    CLEAR_STATUS_PULSE <= ~CFG3_ACTIVE.clear_or_resume_select;
                                end
                                default: begin
                                    spi_state_reg <= CBC_S_IGNORE;
                                end
                            endcase
                        end
                    end
                    CBC_S_ADDR: begin
                        addr_reg <= addr_next;
                        if (bit_cnt_reg == 5'h17) begin
                            bit_cnt_reg <= 5'h00;
                            if (op_reg == `CBC_OP_REG_READ) begin
                                spi_state_reg <= CBC_S_READ;
                                rd_shift_reg  <= read_mux(addr_next);
                            end else begin
                                spi_state_reg <= CBC_S_WRITE;
                            end
                        end
                    end
                    CBC_S_WRITE: begin
                        if (bit_cnt_reg == 5'h07) begin
                            spi_state_reg   <= CBC_S_IGNORE;
                            wr_data_reg     <= byte_next;
                            wr_addr_reg     <= addr_reg;
                            wr_pulse_reg    <= (op_reg == `CBC_OP_REG_WRITE);
                            burst_pulse_reg <= (op_reg == `CBC_OP_SET_BURST);
                        end
                    end
                    default: begin
                        bit_cnt_reg <= 5'h00;
                    end
                endcase
            end else if (sck_fall && spi_state_reg == CBC_S_READ) begin
                // same register repeats: no burst wrap on register reads
                SO           <= rd_shift_reg[7];
                SO_OE_N      <= 1'b0;
                rd_shift_reg <= {rd_shift_reg[6:0], rd_shift_reg[7]};
            end
        end
    end

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    // one-time flips: a bit may change only if it never changed before
    assign cfg3_flip = (wr_data_reg ^ cfg3_nv_reg) & ~cfg3_used_reg & `CBC_CFG3_MASK;
    assign cfg4_flip = (wr_data_reg ^ cfg4_nv_reg) & ~cfg4_used_reg & `CBC_CFG4_MASK;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            cfg3_nv_reg   <= `CBC_CFG3_NV_RST;
            cfg3_used_reg <= 8'h00;
            cfg4_nv_reg   <= `CBC_CFG4_NV_RST;
            cfg4_used_reg <= 8'h00;
            CFG3_ACTIVE   <= `CBC_CFG3_NV_RST;
            WRAP_ACTIVE   <= `CBC_CFG4_NV_RST;
        end else if (reload) begin
            CFG3_ACTIVE <= cfg3_nv_reg;
            WRAP_ACTIVE <= cfg4_nv_reg;
        end else if (burst_pulse_reg) begin
            WRAP_ACTIVE <= wr_data_reg & `CBC_CFG4_MASK;
        end else if (wr_pulse_reg) begin
            case (wr_addr_reg)
                `CBC_ADDR_CFG3_NV: begin
                    cfg3_nv_reg   <= cfg3_nv_reg ^ cfg3_flip;
                    cfg3_used_reg <= cfg3_used_reg | cfg3_flip;
                end
                `CBC_ADDR_CFG4_NV: begin
                    cfg4_nv_reg   <= cfg4_nv_reg ^ cfg4_flip;
                    cfg4_used_reg <= cfg4_used_reg | cfg4_flip;
                end
                `CBC_ADDR_CFG3_V: begin
                    // layout bit is read only; reserved bits stay zero
                    CFG3_ACTIVE <= (wr_data_reg & `CBC_CFG3_MASK & ~8'h08)
                                 | (CFG3_ACTIVE & 8'h08);
                end
                `CBC_ADDR_CFG4_V: begin
                    WRAP_ACTIVE <= wr_data_reg & `CBC_CFG4_MASK;
                end
                default: begin
                    CFG3_ACTIVE <= CFG3_ACTIVE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // erase gating with blank check
    // ------------------------------------------------------------------------
    // every erase kind passes through here
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            erase_state_reg  <= CBC_E_IDLE;
            BLANK_SCAN_START <= 1'b0;
            ERASE_START      <= 1'b0;
            ERASE_SKIP       <= 1'b0;
        end else begin
            BLANK_SCAN_START <= 1'b0;
            ERASE_START      <= 1'b0;
            ERASE_SKIP       <= 1'b0;
            case (erase_state_reg)
                CBC_E_IDLE: begin
                    if (ERASE_REQ) begin
                        if (!CFG3_ACTIVE.blank_check_enable || !SECTOR_ERASE_OK) begin
                            ERASE_START <= 1'b1;
                        end else begin
                            BLANK_SCAN_START <= 1'b1;
                            erase_state_reg  <= CBC_E_SCAN;
                        end
                    end
                end
                CBC_E_SCAN: begin
                    if (BLANK_DONE) begin
                        ERASE_START     <= BLANK_ZERO_FOUND;
                        ERASE_SKIP      <= ~BLANK_ZERO_FOUND;
                        erase_state_reg <= CBC_E_IDLE;
                    end
                end
                default: begin
                    erase_state_reg <= CBC_E_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // page buffer load address
    // ------------------------------------------------------------------------
    // 256 mode keeps the top bit clear and wraps 255 to 0
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PBUF_ADDR <= 9'h000;
        end else if (PBUF_LOAD_START) begin
            PBUF_ADDR <= CFG3_ACTIVE.page_buffer_wrap_select ? PBUF_START_ADDR
                       : {1'b0, PBUF_START_ADDR[7:0]};
        end else if (PBUF_LOAD_STROBE) begin
            PBUF_ADDR <= CFG3_ACTIVE.page_buffer_wrap_select ? PBUF_ADDR + 9'h001
                       : {1'b0, PBUF_ADDR[7:0] + 8'h01};
        end
    end

endmodule : cbc_config
`default_nettype wire

//--- shared/cbc_defs.svh
// Purpose: constants of the command-behaviour configuration block
// Assumes: 24-bit register addresses on the serial link
// Notes:   offsets, masks, reset values, field positions and opcodes only
`ifndef CBC_DEFS_SVH
`define CBC_DEFS_SVH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define CBC_OP_REG_READ    8'h65
`define CBC_OP_REG_WRITE   8'h71
`define CBC_OP_SET_BURST   8'hC0
`define CBC_OP_LEGACY_RST  8'hF0
`define CBC_OP_RST_ARM     8'h66
`define CBC_OP_RST_GO      8'h99
`define CBC_OP_CLR_RESUME  8'h30

// ----------------------------------------------------------------------------
// register addresses on the link
// ----------------------------------------------------------------------------
`define CBC_ADDR_CFG3_NV   24'h000004
`define CBC_ADDR_CFG3_V    24'h800004
`define CBC_ADDR_CFG4_NV   24'h000005
`define CBC_ADDR_CFG4_V    24'h800005

// ----------------------------------------------------------------------------
// reset values, writable masks, field positions
// ----------------------------------------------------------------------------
`define CBC_CFG3_NV_RST    8'h00
`define CBC_CFG4_NV_RST    8'h10
`define CBC_CFG3_MASK      8'h3F
`define CBC_CFG4_MASK      8'h13
`define CBC_UNIFORM_BIT    3
`define CBC_PBUF_HALF      9'h100

`endif

//--- shared/cbc_pkg.sv
// Purpose: types of the command-behaviour configuration block
// Assumes: nothing
// Notes:   field order matches the bit order of the registers
package cbc_pkg;

    // ------------------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       rsvd7;
        logic       rsvd6;
        logic       blank_check_enable;
        logic       page_buffer_wrap_select;
        logic       uniform_sector_status;
        logic       clear_or_resume_select;
        logic       block_erase_size_select;
        logic       legacy_reset_enable;
    } cbc_cfg3_t;

    typedef struct packed {
        logic [2:0] rsvd_hi;
        logic       wrap_disable;
        logic [1:0] rsvd_lo;
        logic [1:0] wrap_len;
    } cbc_cfg4_t;

    // ------------------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CBC_S_OPCODE = 3'b000,
        CBC_S_ADDR   = 3'b001,
        CBC_S_WRITE  = 3'b010,
        CBC_S_READ   = 3'b011,
        CBC_S_IGNORE = 3'b100
    } cbc_spi_state_t;

    typedef enum logic [0:0] {
        CBC_E_IDLE = 1'b0,
        CBC_E_SCAN = 1'b1
    } cbc_erase_state_t;

endpackage : cbc_pkg

//--- bench/cbc_host_model.sv
// Purpose: host side of the serial register link
// Assumes: mode 0, 800 ns link clock, MSB first
// Notes:   link clock stands still between frames
`timescale 1ns/100ps
`default_nettype none
module cbc_host_model (
    input  wire logic MCLK,
    input  wire logic SO,
    output logic      SCK,
    output logic      CS_N,
    output logic      SI
);
    // idle levels of the link
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b1;
    end

    // one frame of nb bits; bits past 32 also return read data
    task automatic xfer(input logic [39:0] bits, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge MCLK);
        CS_N = 1'b0;
        for (int i = 0; i < nb; i++) begin
            SI = bits[39-i];
            SCK = 1'b0;
            repeat (4) @(negedge MCLK);
            SCK = 1'b1;
            repeat (4) @(negedge MCLK);
            if (i >= 32)
                rd = {rd[6:0], SO};
        end
        SCK = 1'b0;
        repeat (4) @(negedge MCLK);
        CS_N = 1'b1;
        SI = ~SI; // no stale level once released
        repeat (6) @(negedge MCLK);
    endtask : xfer
endmodule : cbc_host_model
`default_nettype wire

//--- bench/cbc_config_properties.sv
// Purpose: timing relations at the configuration block ports
// Assumes: single clock domain, reset disables all checks
// Notes:   bound into every instance of the block
`timescale 1ns/100ps
`default_nettype none
module cbc_config_properties (
    input wire logic               MCLK,
    input wire logic               RST,
    input wire logic               HW_RESET_N,
    input wire cbc_pkg::cbc_cfg3_t CFG3_ACTIVE,
    input wire cbc_pkg::cbc_cfg4_t WRAP_ACTIVE,
    input wire logic               RESUME_PULSE,
    input wire logic               CLEAR_STATUS_PULSE,
    input wire logic               ERASE_REQ,
    input wire logic               SECTOR_ERASE_OK,
    input wire logic               BLANK_DONE,
    input wire logic               BLANK_ZERO_FOUND,
    input wire logic               BLANK_SCAN_START,
    input wire logic               ERASE_START,
    input wire logic               ERASE_SKIP,
    input wire logic               PBUF_LOAD_START,
    input wire logic               PBUF_LOAD_STROBE,
    input wire logic [8:0]         PBUF_ADDR
);
    import cbc_pkg::*;
    logic scan_reg;
    logic busy;

    // blank scan in flight, from its start pulse to its done
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST)
            scan_reg <= 1'b0;
        else
            scan_reg <= busy & ~BLANK_DONE;
    end
    assign busy = scan_reg | BLANK_SCAN_START;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // erase group, page buffer, reserved bits, opcode pulses, reload
    property p_erase_direct;
        ERASE_REQ && !busy && !(CFG3_ACTIVE.blank_check_enable && SECTOR_ERASE_OK)
            |=> ERASE_START && !BLANK_SCAN_START;
    endproperty
    a_erase_direct: assert property (p_erase_direct) else $error("erase not direct");
    property p_erase_scan;
        ERASE_REQ && !busy && CFG3_ACTIVE.blank_check_enable && SECTOR_ERASE_OK
            |=> BLANK_SCAN_START && !ERASE_START;
    endproperty
    a_erase_scan: assert property (p_erase_scan) else $error("scan not started");
    property p_scan_result;
        BLANK_DONE && busy |=> ERASE_START == $past(BLANK_ZERO_FOUND)
            && ERASE_SKIP == !$past(BLANK_ZERO_FOUND);
    endproperty
    a_scan_result: assert property (p_scan_result) else $error("scan result wrong");
    property p_pbuf_256;
        PBUF_LOAD_STROBE && !PBUF_LOAD_START && !CFG3_ACTIVE.page_buffer_wrap_select
            |=> PBUF_ADDR == (($past(PBUF_ADDR) + 9'h001) & 9'h0FF);
    endproperty
    a_pbuf_256: assert property (p_pbuf_256) else $error("256 wrap wrong");
    property p_pbuf_512;
        PBUF_LOAD_STROBE && !PBUF_LOAD_START && CFG3_ACTIVE.page_buffer_wrap_select
            |=> PBUF_ADDR == $past(PBUF_ADDR) + 9'h001;
    endproperty
    a_pbuf_512: assert property (p_pbuf_512) else $error("512 step wrong");
    property p_reserved_zero;
        CFG3_ACTIVE.rsvd7 == 1'b0 && CFG3_ACTIVE.rsvd6 == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
    property p_30h_select;
        (RESUME_PULSE |-> CFG3_ACTIVE.clear_or_resume_select ##1 !RESUME_PULSE) and
        (CLEAR_STATUS_PULSE |-> !CFG3_ACTIVE.clear_or_resume_select ##1 !CLEAR_STATUS_PULSE);
    endproperty
    a_30h_select: assert property (p_30h_select) else $error("30h pulse wrong");
    property p_reload_hold;
        !HW_RESET_N [*5] |=> $stable(CFG3_ACTIVE) && $stable(WRAP_ACTIVE);
    endproperty
    a_reload_hold: assert property (p_reload_hold) else $error("reload not held");
endmodule : cbc_config_properties

bind cbc_config cbc_config_properties u_props (
    .MCLK, .RST, .HW_RESET_N, .CFG3_ACTIVE, .WRAP_ACTIVE, .RESUME_PULSE, .CLEAR_STATUS_PULSE,
    .ERASE_REQ, .SECTOR_ERASE_OK, .BLANK_DONE, .BLANK_ZERO_FOUND, .BLANK_SCAN_START,
    .ERASE_START, .ERASE_SKIP, .PBUF_LOAD_START, .PBUF_LOAD_STROBE, .PBUF_ADDR);
`default_nettype wire

//--- bench/cbc_config_tb.sv
// Purpose: self-checking bench of the configuration block
// Assumes: host model drives the link, bench the other inputs
// Notes:   inputs change at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
`include "cbc_defs.svh"
module cbc_config_tb;
    import cbc_pkg::*;
    logic       mclk = 1'b0, rst = 1'b1, hw_reset_n = 1'b1, sck, cs_n, si, so, so_oe_n;
    logic       erase_req = 1'b0, erase_ok = 1'b0, blank_done = 1'b0, zero_found = 1'b0;
    logic       pb_start = 1'b0, pb_strobe = 1'b0, scan_start, erase_start, erase_skip;
    logic       soft_p, clr_p, res_p;
    logic [8:0] pb_start_addr = 9'h000, pb_addr;
    logic [7:0] rd;
    cbc_cfg3_t  cfg3;
    cbc_cfg4_t  cfg4;
    int         n_errors = 0, samples_checked = 0, n_soft = 0, n_clr = 0, n_res = 0;

    cbc_config DUT (
        .MCLK(mclk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SI(si), .HW_RESET_N(hw_reset_n),
        .SO(so), .SO_OE_N(so_oe_n), .CFG3_ACTIVE(cfg3), .WRAP_ACTIVE(cfg4),
        .SOFT_RESET_PULSE(soft_p), .CLEAR_STATUS_PULSE(clr_p), .RESUME_PULSE(res_p),
        .ERASE_REQ(erase_req), .SECTOR_ERASE_OK(erase_ok), .BLANK_DONE(blank_done),
        .BLANK_ZERO_FOUND(zero_found), .BLANK_SCAN_START(scan_start),
        .ERASE_START(erase_start), .ERASE_SKIP(erase_skip), .PBUF_LOAD_START(pb_start),
        .PBUF_START_ADDR(pb_start_addr), .PBUF_LOAD_STROBE(pb_strobe), .PBUF_ADDR(pb_addr));
    cbc_host_model u_host (.MCLK(mclk), .SO(so), .SCK(sck), .CS_N(cs_n), .SI(si));

    // clock and pulse counters
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (soft_p === 1'b1) n_soft++;
        if (clr_p === 1'b1) n_clr++;
        if (res_p === 1'b1) n_res++;
    end

    // compare and verdict
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // link commands
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        u_host.xfer({`CBC_OP_REG_WRITE, a, d}, 40, rd);
    endtask : wr
    task automatic op(input logic [7:0] o);
        u_host.xfer({o, 32'h0}, 8, rd);
    endtask : op
    task automatic rdchk(input logic [23:0] a, input logic [7:0] e);
        u_host.xfer({`CBC_OP_REG_READ, a, 8'h00}, 40, rd);
        chk("read", 9'(rd), 9'(e));
    endtask : rdchk

    // erase request with expected scan outcome
    task automatic erase(input logic ok, input logic zero, input logic bc);
        @(negedge mclk);
        erase_req = 1'b1;
        erase_ok = ok;
        @(negedge mclk);
        erase_req = 1'b0;
        chk("scan", 9'(scan_start), 9'(bc & ok));
        chk("erase", 9'(erase_start), 9'(!(bc & ok)));
        if (bc & ok) begin
            blank_done = 1'b1;
            zero_found = zero;
            @(negedge mclk);
            blank_done = 1'b0;
            chk("erase", 9'(erase_start), 9'(zero));
            chk("skip", 9'(erase_skip), 9'(!zero));
        end
    endtask : erase

    // load at 0FE, then two strobes
    task automatic pbuf(input logic [8:0] last);
        @(negedge mclk);
        pb_start = 1'b1;
        pb_start_addr = 9'h0FE;
        @(negedge mclk);
        pb_start = 1'b0;
        pb_strobe = 1'b1;
        chk("pbuf", pb_addr, 9'h0FE);
        @(negedge mclk);
        chk("pbuf", pb_addr, 9'h0FF);
        @(negedge mclk);
        pb_strobe = 1'b0;
        chk("pbuf", pb_addr, last);
    endtask : pbuf

    // watchdog
    initial begin
        repeat (100000) @(posedge mclk);
        n_errors++;
        $display("[FAIL] run expected end seen timeout");
        results();
    end

    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        chk("cfg3", 9'(cfg3), 9'h000);
        chk("cfg4", 9'(cfg4), 9'h010);
        chk("oe", 9'(so_oe_n), 9'h001);
        rdchk(`CBC_ADDR_CFG3_NV, 8'h00);
        rdchk(`CBC_ADDR_CFG4_NV, 8'h10);
        rdchk(24'h000123, 8'h00);
        wr(`CBC_ADDR_CFG3_V, 8'hE5);
        chk("cfg3", 9'(cfg3), 9'h025);
        rdchk(`CBC_ADDR_CFG3_V, 8'h25);
        op(`CBC_OP_CLR_RESUME);
        chk("resume", 9'(n_res), 9'h001);
        op(`CBC_OP_LEGACY_RST);
        chk("soft", 9'(n_soft), 9'h001);
        chk("cfg3", 9'(cfg3), 9'h000);
        op(`CBC_OP_CLR_RESUME);
        chk("clear", 9'(n_clr), 9'h001);
        op(`CBC_OP_LEGACY_RST);
        op(`CBC_OP_RST_GO);
        chk("soft", 9'(n_soft), 9'h001);
        op(`CBC_OP_RST_ARM);
        op(`CBC_OP_RST_GO);
        chk("soft", 9'(n_soft), 9'h002);
        wr(`CBC_ADDR_CFG4_V, 8'hFF);
        chk("cfg4", 9'(cfg4), 9'h013);
        u_host.xfer({`CBC_OP_SET_BURST, 8'h01, 24'h0}, 16, rd);
        chk("cfg4", 9'(cfg4), 9'h001);
        rdchk(`CBC_ADDR_CFG4_V, 8'h01);
        wr(`CBC_ADDR_CFG3_NV, 8'h07);
        rdchk(`CBC_ADDR_CFG3_NV, 8'h07);
        chk("cfg3", 9'(cfg3), 9'h000);
        wr(`CBC_ADDR_CFG3_NV, 8'h00);
        rdchk(`CBC_ADDR_CFG3_NV, 8'h07);
        hw_reset_n = 1'b0;
        repeat (6) @(negedge mclk);
        hw_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        chk("cfg3", 9'(cfg3), 9'h007);
        chk("cfg4", 9'(cfg4), 9'h010);
        wr(`CBC_ADDR_CFG3_V, 8'h27);
        chk("cfg3", 9'(cfg3), 9'h027);
        erase(1'b0, 1'b0, 1'b1);
        erase(1'b1, 1'b1, 1'b1);
        erase(1'b1, 1'b0, 1'b1);
        pbuf(9'h000);
        wr(`CBC_ADDR_CFG3_V, 8'h10);
        erase(1'b1, 1'b0, 1'b0);
        pbuf(9'h100);
        results();
    end
endmodule : cbc_config_tb
`default_nettype wire
